// [fsp_device.sv]
// Flash self-programming controller: page buffer, erase, write and special reads
module fsp_device #(
  parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  fsp_if.dev                        link,
  input  wire logic [47:0]          sigRow,
  input  wire logic [23:0]          fuseBits,
  input  wire logic [7:0]           lockBits,
  output logic [fsp_pkg::PAGES-1:0] pageProgrammed
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [5:0]                                      ctl;
    logic [2:0]                                      arm;
    fsp_pkg::fsp_op_e                                op;
    logic [fsp_pkg::PAGE_W-1:0]                      page;
    logic [fsp_pkg::PROG_CNT_W-1:0]                  cnt;
    logic                                            halt;
    logic [7:0]                                      csrRd;
    logic [7:0]                                      lpmData;
    logic                                            lpmValid;
    logic [fsp_pkg::PAGES-1:0]                       done;
    logic [fsp_pkg::WORDS-1:0][15:0]                 pageBuf;
    logic [fsp_pkg::PAGES*fsp_pkg::WORDS-1:0][15:0]  flash;
  } fsp_dev_st_s;

  fsp_dev_st_s q;
  fsp_dev_st_s d;

  localparam logic [fsp_pkg::PROG_CNT_W-1:0] PROG_LAST = fsp_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

  // Only the six documented patterns count as commands
  function automatic logic cmdOk(input logic [5:0] v);
    return (v == fsp_pkg::CMD_LOAD) || (v == fsp_pkg::CMD_ERASE) || (v == fsp_pkg::CMD_WRITE) ||
           (v == fsp_pkg::CMD_FUSE) || (v == fsp_pkg::CMD_CLEAR) || (v == fsp_pkg::CMD_SIG);
  endfunction : cmdOk

  // Byte picker shared by the signature and fuse reads
  function automatic logic [7:0] pickByte(input logic [63:0] v, input logic [2:0] idx);
    return v[{idx, 3'h0} +: 8];
  endfunction : pickByte

  logic [fsp_pkg::WORD_W-1:0] zWord;
  logic [fsp_pkg::PAGE_W-1:0] zPage;
  logic                       zByte;
  logic                       armed;

  // Pointer fields; bits outside them are never looked at
  assign zWord = link.zPtr[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];
  assign zPage = link.zPtr[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_W];
  assign zByte = link.zPtr[fsp_pkg::BYTE_BIT];
  assign armed = (q.arm != 3'h0) && (q.op == fsp_pkg::OP_IDLE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [15:0] word;
    word = 16'h0000;
    d = q;
    d.lpmValid = 1'b0;

    // Arming window; a command not used in time drops all its bits
    if (armed) begin
      d.arm = q.arm - 3'h1;
      if (q.arm == 3'h1) begin
        d.ctl = 6'h00;
      end
    end

    // Control writes: refused while an operation runs
    if (link.csrWrEn && (q.op == fsp_pkg::OP_IDLE) && cmdOk(link.csrWrData[5:0])) begin
      d.ctl = link.csrWrData[5:0];
      d.arm = fsp_pkg::ARM_SPM;
      if (link.csrWrData[5:0] == fsp_pkg::CMD_CLEAR) begin
        d.pageBuf = '{default: fsp_pkg::ERASED};
      end
    end

    // Store instruction inside the window
    if (link.spmStrobe && armed) begin
      unique case (q.ctl)
        fsp_pkg::CMD_LOAD: begin
          d.pageBuf[zWord] = link.dataPair;
          d.ctl = 6'h00;
          d.arm = 3'h0;
        end
        fsp_pkg::CMD_ERASE: begin
          d.op   = fsp_pkg::OP_ERASE;
          d.page = zPage;
          d.cnt  = '0;
          d.halt = 1'b1;
          d.arm  = 3'h0;
        end
        fsp_pkg::CMD_WRITE: begin
          d.op   = fsp_pkg::OP_WRITE;
          d.page = zPage;
          d.cnt  = '0;
          d.halt = 1'b1;
          d.arm  = 3'h0;
        end
        fsp_pkg::CMD_CLEAR: begin
          d.ctl = 6'h00;
          d.arm = 3'h0;
        end
        default: begin
          d.ctl = q.ctl;
        end
      endcase
    end

    // Running operation: enable bit and command bit stay until the end
    if (q.op != fsp_pkg::OP_IDLE) begin
      d.cnt = q.cnt + fsp_pkg::PROG_CNT_W'(1);
      if (q.cnt == PROG_LAST) begin
        for (int i = 0; i < fsp_pkg::WORDS; i++) begin
          if (q.op == fsp_pkg::OP_WRITE) begin
            d.flash[{q.page, fsp_pkg::WORD_W'(i)}] = q.pageBuf[i];
          end else begin
            d.flash[{q.page, fsp_pkg::WORD_W'(i)}] = fsp_pkg::ERASED;
          end
        end
        if (q.op == fsp_pkg::OP_WRITE) begin
          d.pageBuf = '{default: fsp_pkg::ERASED};
          d.done[q.page] = 1'b1;
        end else begin
          d.done[q.page] = 1'b0;
        end
        d.op   = fsp_pkg::OP_IDLE;
        d.halt = 1'b0;
        d.ctl  = 6'h00;
        d.cnt  = '0;
      end
    end

    // Load instruction: special reads only in the first three cycles
    if (link.lpmStrobe && (q.op == fsp_pkg::OP_IDLE)) begin
      d.lpmValid = 1'b1;
      if (armed && (q.arm >= fsp_pkg::ARM_LPM_MIN) && (q.ctl == fsp_pkg::CMD_SIG)) begin
        d.lpmData = pickByte({16'h0000, sigRow}, link.zPtr[2:0]);
        d.ctl = 6'h00;
        d.arm = 3'h0;
      end else if (armed && (q.arm >= fsp_pkg::ARM_LPM_MIN) && (q.ctl == fsp_pkg::CMD_FUSE)) begin
        // Order in the pointer: low fuse, lock, extended fuse, high fuse
        d.lpmData = pickByte({32'h0000_0000, fuseBits[15:8], fuseBits[23:16], lockBits, fuseBits[7:0]},
                             {1'b0, link.zPtr[1:0]});
        d.ctl = 6'h00;
        d.arm = 3'h0;
      end else begin
        word = q.flash[{zPage, zWord}];
        d.lpmData = zByte ? word[15:8] : word[7:0];
      end
    end

    // An EEPROM write in the middle of loading loses the buffer
    if (link.eeWrite) begin
      d.pageBuf = '{default: fsp_pkg::ERASED};
    end

    // Read-back image; the top two bits are hard zero
    d.csrRd = {2'b00, d.ctl};
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset also empties the page buffer; the flash image starts erased
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.ctl      <= 6'h00;
      q.arm      <= 3'h0;
      q.op       <= fsp_pkg::OP_IDLE;
      q.page     <= '0;
      q.cnt      <= '0;
      q.halt     <= 1'b0;
      q.csrRd    <= fsp_pkg::CSR_RESET;
      q.lpmData  <= 8'h00;
      q.lpmValid <= 1'b0;
      q.done     <= '0;
      q.pageBuf  <= '{default: fsp_pkg::ERASED};
      q.flash    <= '{default: fsp_pkg::ERASED};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // All straight from flops so the CPU end sees clean levels
  assign link.csrRdData = q.csrRd;
  assign link.lpmData   = q.lpmData;
  assign link.lpmValid  = q.lpmValid;
  assign link.cpuHalt   = q.halt;
  assign pageProgrammed = q.done;

endmodule : fsp_device

// [fsp_host.sv]
// CPU-side end: APB registers that issue control writes, store and load instructions
module fsp_host (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  fsp_if.cpu               link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        csrWr;
    logic [7:0]  csrData;
    logic        spm;
    logic        load_program_instruction;
    logic        eeWr;
    logic [15:0] zPtr;
    logic [15:0] dataPair;
    logic [7:0]  lpmByte;
    logic        lpmSeen;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fsp_host_st_s;

  fsp_host_st_s q;
  fsp_host_st_s d;

  function automatic logic mapped(input logic [7:0] a);
    return (a == fsp_pkg::ADDR_CTRL) || (a == fsp_pkg::ADDR_ZPTR) || (a == fsp_pkg::ADDR_DATA) ||
           (a == fsp_pkg::ADDR_ACTION) || (a == fsp_pkg::ADDR_STATUS);
  endfunction : mapped

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.csrWr   = 1'b0;
    d.spm     = 1'b0;
    d.load_program_instruction     = 1'b0;
    d.eeWr    = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.prdata  = 32'h0000_0000;

    // Access phase: one wait state, longer while the core is halted
    if (psel && penable && !q.pready && !link.cpuHalt) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped(paddr);
      unique case (paddr)
        fsp_pkg::ADDR_CTRL:   d.prdata = {24'h00_0000, link.csrRdData};
        fsp_pkg::ADDR_ZPTR:   d.prdata = {16'h0000, q.zPtr};
        fsp_pkg::ADDR_DATA:   d.prdata = {16'h0000, q.dataPair};
        fsp_pkg::ADDR_STATUS: d.prdata = {23'h00_0000, q.lpmSeen, q.lpmByte};
        default:              d.prdata = 32'h0000_0000;
      endcase
    end

    // Writes take effect at the edge that completes the transfer
    if (psel && penable && q.pready && pwrite) begin
      unique case (paddr)
        fsp_pkg::ADDR_CTRL: begin
          d.csrWr   = 1'b1;
          d.csrData = pwdata[7:0];
        end
        fsp_pkg::ADDR_ZPTR:   d.zPtr = pwdata[15:0];
        fsp_pkg::ADDR_DATA:   d.dataPair = pwdata[15:0];
        fsp_pkg::ADDR_ACTION: begin
          d.spm  = pwdata[fsp_pkg::ACT_SPM];
          d.load_program_instruction  = pwdata[fsp_pkg::ACT_LPM];
          d.eeWr = pwdata[fsp_pkg::ACT_EEWR];
        end
        fsp_pkg::ADDR_STATUS: begin
          if (pwdata[fsp_pkg::STAT_VALID]) begin
            d.lpmSeen = 1'b0;
          end
        end
        default: d.csrWr = 1'b0;
      endcase
    end

    // A load answer arriving with a clear still sets the flag
    if (link.lpmValid) begin
      d.lpmByte = link.lpmData;
      d.lpmSeen = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign link.csrWrEn   = q.csrWr;
  assign link.csrWrData = q.csrData;
  assign link.spmStrobe = q.spm;
  assign link.lpmStrobe = q.load_program_instruction;
  assign link.eeWrite   = q.eeWr;
  assign link.zPtr      = q.zPtr;
  assign link.dataPair  = q.dataPair;
  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;

endmodule : fsp_host

// [fsp_if.sv]
// Link between the CPU-side end and the flash self-programming controller
interface fsp_if;
  logic        csrWrEn;       // One-cycle control register write
  logic [7:0]  csrWrData;
  logic [7:0]  csrRdData;     // Control register as read back
  logic        spmStrobe;     // One-cycle store-program instruction
  logic        lpmStrobe;     // One-cycle load-program instruction
  logic        eeWrite;       // One-cycle EEPROM write event
  logic [15:0] zPtr;
  logic [15:0] dataPair;
  logic [7:0]  lpmData;
  logic        lpmValid;      // One-cycle load answer
  logic        cpuHalt;

  modport dev (
    input  csrWrEn, csrWrData, spmStrobe, lpmStrobe, eeWrite, zPtr, dataPair,
    output csrRdData, lpmData, lpmValid, cpuHalt
  );
  modport cpu (
    output csrWrEn, csrWrData, spmStrobe, lpmStrobe, eeWrite, zPtr, dataPair,
    input  csrRdData, lpmData, lpmValid, cpuHalt
  );
endinterface : fsp_if

// [fsp_pkg.sv]
// Shared constants and types of the flash self-programming controller and its CPU-side end
package fsp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_MIN_NS   = 3_700_000;        // Shortest erase or write time
  localparam int unsigned PROG_MAX_NS   = 4_500_000;        // Longest erase or write time
  // Least time, so round up to whole cycles
  localparam int unsigned PROG_CYCLES   = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W    = 19;
  localparam logic [2:0]  ARM_SPM       = 3'h4;             // Cycles an armed command waits for a store
  localparam logic [2:0]  ARM_LPM_MIN   = 3'h2;             // Count still open for a special load

  // ****************************************************************
  // Flash geometry and pointer fields
  // ****************************************************************
  localparam int unsigned WORDS      = 8;
  localparam int unsigned PAGES      = 4;
  localparam int unsigned WORD_W     = 3;
  localparam int unsigned PAGE_W     = 2;
  localparam int unsigned WORD_LSB   = 1;                   // Word field sits above the byte bit
  localparam int unsigned PAGE_LSB   = 4;
  localparam int unsigned BYTE_BIT   = 0;
  localparam logic [15:0] ERASED     = 16'hFFFF;

  // ****************************************************************
  // Control register commands, lower six bits
  // ****************************************************************
  localparam logic [5:0] CMD_LOAD  = 6'h01;
  localparam logic [5:0] CMD_ERASE = 6'h03;
  localparam logic [5:0] CMD_WRITE = 6'h05;
  localparam logic [5:0] CMD_FUSE  = 6'h09;
  localparam logic [5:0] CMD_CLEAR = 6'h11;
  localparam logic [5:0] CMD_SIG   = 6'h21;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // ****************************************************************
  // CPU-side register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ZPTR   = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_ACTION = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int unsigned ACT_SPM    = 0;
  localparam int unsigned ACT_LPM    = 1;
  localparam int unsigned ACT_EEWR   = 2;
  localparam int unsigned STAT_VALID = 8;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10
  } fsp_op_e;

endpackage : fsp_pkg

// [fsp_properties.sv]
// Concurrent checks on the link between the CPU-side end and the flash controller
module fsp_properties #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       csrWrEn,
  input wire logic [7:0] csrRdData,
  input wire logic       spmStrobe,
  input wire logic       lpmStrobe,
  input wire logic       lpmValid,
  input wire logic       cpuHalt
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HMAX = PROG_CYCLES + 1;
  logic [7:0] haltLen_q, haltLen_d, armLen_q, armLen_d;

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  // A fresh control write restarts the arm count, so only one window is measured
  always_comb begin
    haltLen_d = cpuHalt ? haltLen_q + 8'h01 : 8'h00;
    armLen_d  = (csrRdData[0] && !cpuHalt && !csrWrEn) ? armLen_q + 8'h01 : 8'h00;
  end
  // Counters restart with reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      haltLen_q <= 8'h00;
      armLen_q  <= 8'h00;
    end else begin
      haltLen_q <= haltLen_d;
      armLen_q  <= armLen_d;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rsvd_zero_a: assert property (csrRdData[7:6] == 2'b00)
    else $error("reserved control bits read nonzero");
  halt_cause_a: assert property ($rose(cpuHalt) |-> $past(spmStrobe) && $past(csrRdData[0]))
    else $error("halt began without an armed store");
  halt_len_a: assert property (cpuHalt |-> haltLen_q < HMAX)
    else $error("halt lasted too long");
  halt_min_a: assert property ($fell(cpuHalt) |-> haltLen_q >= PROG_CYCLES - 1)
    else $error("halt released early");
  enable_held_a: assert property (cpuHalt |-> csrRdData[0] && (csrRdData[2] != csrRdData[1]))
    else $error("control bits wrong during operation");
  arm_bound_a: assert property (csrRdData[0] && !cpuHalt |-> armLen_q < 8'd4)
    else $error("armed command outlived its window");
  load_answer_a: assert property (lpmStrobe && !cpuHalt |=> lpmValid)
    else $error("load got no answer");
  busy_load_a: assert property (lpmStrobe && cpuHalt |=> !lpmValid)
    else $error("load answered while halted");
  sig_store_a: assert property (spmStrobe && csrRdData[5] |=> !cpuHalt)
    else $error("store with signature armed started an operation");
  busy_cmd_a: assert property (csrWrEn && cpuHalt |=> !cpuHalt || $stable(csrRdData))
    else $error("command taken during operation");
  // Main scenarios reached
  cover property ($rose(cpuHalt) && csrRdData[1]);
  cover property ($rose(cpuHalt) && csrRdData[2]);
  cover property (lpmStrobe && csrRdData[5]);
  cover property (lpmStrobe && csrRdData[3]);
endmodule : fsp_properties

// [testbench.sv]
// Self-checking bench: APB-driven CPU end joined to the flash controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PC   = 20;              // Shortened programming time
  localparam logic [47:0] SIG  = 48'h6655_4433_2211;
  localparam logic [23:0] FUSE = 24'hA1_B2C3;
  localparam logic [7:0]  LOCK = 8'h3C;
  typedef struct packed {
    logic [5:0] cmd;
    logic [2:0] z;
    logic [7:0] exp;
  } fsp_row_s;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pageProgrammed;
  int          n_errors, cmp_count;
  // Special reads: signature bytes, then fuse and lock bytes
  fsp_row_s rows [12] = '{
    '{fsp_pkg::CMD_SIG, 3'h0, 8'h11}, '{fsp_pkg::CMD_SIG, 3'h1, 8'h22}, '{fsp_pkg::CMD_SIG, 3'h2, 8'h33},
    '{fsp_pkg::CMD_SIG, 3'h3, 8'h44}, '{fsp_pkg::CMD_SIG, 3'h4, 8'h55}, '{fsp_pkg::CMD_SIG, 3'h5, 8'h66},
    '{fsp_pkg::CMD_SIG, 3'h6, 8'h00}, '{fsp_pkg::CMD_SIG, 3'h7, 8'h00}, '{fsp_pkg::CMD_FUSE, 3'h0, 8'hC3},
    '{fsp_pkg::CMD_FUSE, 3'h1, 8'h3C}, '{fsp_pkg::CMD_FUSE, 3'h2, 8'hA1}, '{fsp_pkg::CMD_FUSE, 3'h3, 8'hB2}};

  fsp_if fspLink ();
  fsp_device #(.PROG_CYCLES(PC)) fsp_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(fspLink),
    .sigRow(SIG), .fuseBits(FUSE), .lockBits(LOCK), .pageProgrammed(pageProgrammed));
  fsp_host fsp_host_inst (.core_clk(core_clk), .rst_n(rst_n), .link(fspLink), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fsp_properties #(.PROG_CYCLES(PC)) fsp_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
    .csrWrEn(fspLink.csrWrEn), .csrRdData(fspLink.csrRdData), .spmStrobe(fspLink.spmStrobe),
    .lpmStrobe(fspLink.lpmStrobe), .lpmValid(fspLink.lpmValid), .cpuHalt(fspLink.cpuHalt));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Leaves psel up so a following transfer starts at once; idle releases it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    if (n >= 500) n_errors++;
    rd = prdata;
    err = pslverr;
  endtask : xfer
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : idle
  task automatic op(input logic [5:0] cmd, input logic [15:0] z, input logic [31:0] act);
    xfer(1'b1, fsp_pkg::ADDR_ZPTR, {16'h0, z});
    xfer(1'b1, fsp_pkg::ADDR_CTRL, {26'h0, cmd});
    xfer(1'b1, fsp_pkg::ADDR_ACTION, act);
  endtask : op
  // The idle cycle lets the load answer land before status is read
  task automatic rdStat(input logic [7:0] exp);
    idle();
    xfer(1'b0, fsp_pkg::ADDR_STATUS, 32'h0);
    chk({23'h0, rd[8:0]}, {23'h0, 1'b1, exp});
    xfer(1'b1, fsp_pkg::ADDR_STATUS, 32'h0000_0100);
  endtask : rdStat
  task automatic rdFlash(input logic [1:0] pg, input logic [2:0] w, input logic [15:0] exp);
    for (int b = 0; b < 2; b++) begin
      xfer(1'b1, fsp_pkg::ADDR_ZPTR, {26'h0, pg, w, 1'(b)});
      xfer(1'b1, fsp_pkg::ADDR_ACTION, 32'h2);
      rdStat(b ? exp[15:8] : exp[7:0]);
    end
  endtask : rdFlash
  task automatic prog(input logic [1:0] pg);
    for (int k = 0; k < 2; k++) begin
      op(k ? fsp_pkg::CMD_WRITE : fsp_pkg::CMD_ERASE, {10'h0, pg, 4'h0}, 32'h1);
      idle();
      repeat (2) @(posedge core_clk);
      chk(32'(fspLink.cpuHalt), 32'h1);
      chk(32'(fspLink.csrRdData), k ? 32'h5 : 32'h3);
      xfer(1'b0, fsp_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
    end
    chk(32'(pageProgrammed[pg]), 32'h1);
  endtask : prog
  function automatic logic [15:0] pat(input logic [1:0] pg, input logic [2:0] w);
    return {5'h15, w, 3'h3, pg, w};
  endfunction : pat
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs about a thousand cycles
  initial begin
    #300_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, n_errors, cmp_count} = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    xfer(1'b0, fsp_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, fsp_pkg::ADDR_CTRL, 32'h0000_00FF);
    idle();
    xfer(1'b0, fsp_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      op(rows[i].cmd, {13'h0, rows[i].z}, 32'h2);
      rdStat(rows[i].exp);
    end
    // Store while signature read armed, then both commands left to time out
    op(fsp_pkg::CMD_SIG, 16'h0, 32'h1);
    idle();
    repeat (2) @(posedge core_clk);
    chk(32'(fspLink.cpuHalt), 32'h0);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, fsp_pkg::ADDR_CTRL, k ? 32'h5 : 32'h3);
      idle();
      repeat (6) @(posedge core_clk);
      xfer(1'b0, fsp_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, fsp_pkg::ADDR_ACTION, 32'h1);
      idle();
      repeat (2) @(posedge core_clk);
      chk(32'(fspLink.cpuHalt), 32'h0);
    end
    chk(32'(pageProgrammed), 32'h0);
    // Words loaded out of order, then erase and write
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, fsp_pkg::ADDR_DATA, {16'h0, pat(2'h2, 3'(i * 3))});
      op(fsp_pkg::CMD_LOAD, {12'h0, 3'(i * 3), 1'b0}, 32'h1);
    end
    prog(2'h2);
    for (int w = 0; w < 8; w++) rdFlash(2'h2, 3'(w), pat(2'h2, 3'(w)));
    prog(2'h1);
    rdFlash(2'h1, 3'h3, 16'hFFFF);
    // Buffer discarded by the clear command, then by an EEPROM write
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, fsp_pkg::ADDR_DATA, {16'h0, pat(2'h3, 3'h0)});
      op(fsp_pkg::CMD_LOAD, 16'h0, 32'h1);
      if (m == 0) op(fsp_pkg::CMD_CLEAR, 16'h0, 32'h1);
      else xfer(1'b1, fsp_pkg::ADDR_ACTION, 32'h4);
      prog(m ? 2'h0 : 2'h3);
      rdFlash(m ? 2'h0 : 2'h3, 3'h0, 16'hFFFF);
    end
    chk(32'(pageProgrammed), 32'hF);
    // Mid-run reset must drop a word already loaded, so the next write programs erased data
    xfer(1'b1, fsp_pkg::ADDR_DATA, {16'h0, pat(2'h0, 3'h0)});
    op(fsp_pkg::CMD_LOAD, 16'h0, 32'h1);
    idle();
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(32'(pageProgrammed), 32'h0);
    xfer(1'b0, fsp_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    prog(2'h0);
    rdFlash(2'h0, 3'h0, 16'hFFFF);
    idle();
    give_verdict();
  end
endmodule : testbench
